/* bench/test_adc_conversion_sequencer.sv */
// Self-checking testbench of the conversion sequencer with a behavioural result model
`timescale 1ns/1ns
`include "acs_params.svh"
module test_adc_conversion_sequencer;
   logic i_ref_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_ext_trigger_pin = 1'b0;
   logic i_trig_edge_rising = 1'b1;
   logic i_cmp = 1'b0;
   logic [7:0] o_rdata;
   logic o_sample;
   logic [7:0] o_dac_code;
   logic o_analog_input_six;
   logic o_analog_input_seven;
   logic o_irq;
   logic [7:0] vin = 8'h00;
   logic [7:0] rd_q;
   logic [7:0] exp_res;
   logic [7:0] mode;
   logic irq_seen;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   int n;
   int periods[4] = '{124, 124, 62, 31};
   logic [7:0] rst_addr[5] = '{`ACS_ADDR_MODE, `ACS_ADDR_START, `ACS_ADDR_IRQ_STAT, `ACS_ADDR_IRQ_EN, 8'h00};
   logic [7:0] rst_val[5] = '{8'h10, 8'h7F, 8'h00, 8'h00, 8'h00};
   logic [3:0] codes[7] = '{4'h0, 4'h4, 4'h8, 4'hA, 4'hB, 4'hC, 4'hF};

   acs_sequencer dut (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .i_wr(i_wr),
      .i_rd(i_rd),
      .o_rdata(o_rdata),
      .i_ext_trigger_pin(i_ext_trigger_pin),
      .i_trig_edge_rising(i_trig_edge_rising),
      .i_cmp(i_cmp),
      .o_sample(o_sample),
      .o_dac_code(o_dac_code),
      .o_analog_input_six(o_analog_input_six),
      .o_analog_input_seven(o_analog_input_seven),
      .o_irq(o_irq)
   );

   // ****************************************
   // Clock, comparator stand-in and hang guard
   // ****************************************
   always #5 i_ref_clk = ~i_ref_clk;

   // Comparator answers for the trial code on the ladder
   always @(posedge i_ref_clk) i_cmp <= (vin >= o_dac_code);

   // Cuts a hang short
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         $display("run exceeded its cycle limit");
         conclude();
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Write cycle: one strobe cycle, returns at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask

   // Read cycle: data is taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 rd_q = o_rdata;
   endtask

   // Successive approximation model of the expected result
   function automatic logic [7:0] sar(input logic [7:0] v);
      logic [7:0] c;
      c = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         if (v >= (c | (8'h01 << b))) c = c | (8'h01 << b);
      end
      return c;
   endfunction

   // New random input voltage and its expected code
   task automatic new_input();
      logic [7:0] v;
      v = 8'($urandom);
      vin <= v;
      exp_res = sar(v);
   endtask

   // Polls the interrupt each cycle, counting edges up to a bound
   task automatic wait_irq(input int lim);
      while (o_irq !== 1'b1 && n < lim) begin
         @(posedge i_ref_clk);
         #1 n++;
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(13));
      repeat (6) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      // Reset values and an unmapped read
      for (int i = 0; i < 5; i++) begin
         rd(rst_addr[i]);
         chk("reset value", rd_q, rst_val[i]);
      end
      chk("irq at reset", {7'h00, o_irq}, 8'h00);
      $display("test reset done");
      // Channel codes, reserved ones route nothing
      foreach (codes[i]) begin
         wr(`ACS_ADDR_MODE, {4'h0, codes[i]});
         #1 chk("route six", {7'h00, o_analog_input_six}, {7'h00, codes[i] == `ACS_CH_SIX});
         chk("route seven", {7'h00, o_analog_input_seven}, {7'h00, codes[i] == `ACS_CH_SEVEN});
      end
      $display("test channels done");
      // Every speed code, restart ignored while active, interrupt path
      wr(`ACS_ADDR_IRQ_EN, 8'h03);
      for (int k = 0; k < 4; k++) begin
         mode = {k[0], 1'b0, k[1], 1'b0, 4'hA};
         wr(`ACS_ADDR_MODE, mode);
         rd(`ACS_ADDR_MODE);
         chk("mode readback", rd_q, mode | 8'h10);
         new_input();
         wr(`ACS_ADDR_START, 8'h80);
         #1 chk("sampling", {7'h00, o_sample}, 8'h01);
         wr(`ACS_ADDR_START, 8'h80);
         rd(`ACS_ADDR_START);
         chk("active", rd_q, 8'hFF);
         n = 4;
         wait_irq(300);
         chk("period", 8'(n), 8'(periods[k]));
         rd(`ACS_ADDR_IRQ_STAT);
         chk("end flag", rd_q, 8'h01);
         rd(`ACS_ADDR_RESULT);
         chk("result", rd_q, exp_res);
         rd(`ACS_ADDR_START);
         chk("idle", rd_q, 8'h7F);
         wr(`ACS_ADDR_IRQ_CLR, 8'h01);
         #1 chk("irq cleared", {7'h00, o_irq}, 8'h00);
      end
      $display("test speeds done");
      // Abort keeps the old result and flags its own event
      wr(`ACS_ADDR_START, 8'h80);
      repeat (10) @(posedge i_ref_clk);
      wr(`ACS_ADDR_START, 8'h00);
      rd(`ACS_ADDR_IRQ_STAT);
      chk("abort flag", rd_q, 8'h02);
      rd(`ACS_ADDR_RESULT);
      chk("result kept", rd_q, exp_res);
      rd(`ACS_ADDR_START);
      chk("aborted idle", rd_q, 8'h7F);
      wr(`ACS_ADDR_IRQ_CLR, 8'h02);
      $display("test abort done");
      // Masked completion stays visible to polling
      wr(`ACS_ADDR_IRQ_EN, 8'h00);
      new_input();
      wr(`ACS_ADDR_START, 8'h80);
      irq_seen = 1'b0;
      repeat (40) begin
         @(posedge i_ref_clk);
         #1 irq_seen = irq_seen | o_irq;
      end
      chk("masked irq", {7'h00, irq_seen}, 8'h00);
      rd(`ACS_ADDR_IRQ_STAT);
      chk("polled flag", rd_q, 8'h01);
      wr(`ACS_ADDR_IRQ_EN, 8'h01);
      #1 chk("unmasked irq", {7'h00, o_irq}, 8'h01);
      wr(`ACS_ADDR_IRQ_EN, 8'h00);
      rd(`ACS_ADDR_IRQ_STAT);
      chk("flag held", rd_q, 8'h01);
      chk("remasked irq", {7'h00, o_irq}, 8'h00);
      wr(`ACS_ADDR_IRQ_CLR, 8'h01);
      rd(`ACS_ADDR_IRQ_STAT);
      chk("flag cleared", rd_q, 8'h00);
      wr(`ACS_ADDR_IRQ_EN, 8'h01);
      $display("test masking done");
      // Trigger pin: ignored when disabled, each edge choice when enabled
      for (int e = 0; e < 2; e++) begin
         wr(`ACS_ADDR_MODE, 8'hAA);
         i_trig_edge_rising <= e[0];
         i_ext_trigger_pin <= ~e[0];
         @(posedge i_ref_clk);
         // Selected edge while the trigger is disabled must not start
         i_ext_trigger_pin <= e[0];
         repeat (40) @(posedge i_ref_clk);
         rd(`ACS_ADDR_IRQ_STAT);
         chk("trigger off", rd_q, 8'h00);
         // Back to the idle level, an edge of the other direction
         i_ext_trigger_pin <= ~e[0];
         wr(`ACS_ADDR_MODE, 8'hEA);
         new_input();
         @(posedge i_ref_clk);
         i_ext_trigger_pin <= e[0];
         n = 0;
         wait_irq(40);
         chk("trigger start", {7'h00, n >= 31 && n <= 33}, 8'h01);
         rd(`ACS_ADDR_RESULT);
         chk("trigger result", rd_q, exp_res);
         wr(`ACS_ADDR_IRQ_CLR, 8'h01);
      end
      $display("test trigger done");
      conclude();
   end
endmodule

/* design/acs_params.svh */
// Offsets, field positions, reset values and timing counts of the conversion sequencer
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ****************************************
// Register offsets on the register port
// ****************************************
`define ACS_ADDR_MODE 8'hC4
`define ACS_ADDR_RESULT 8'hC5
`define ACS_ADDR_START 8'hC6
`define ACS_ADDR_IRQ_STAT 8'hC8
`define ACS_ADDR_IRQ_CLR 8'hC9
`define ACS_ADDR_IRQ_EN 8'hCA

// ****************************************
// Field positions and reset values
// ****************************************
`define ACS_BIT_SPD_LO 7
`define ACS_BIT_EXT_TRIGGER_ENABLE 6
`define ACS_BIT_SPD_HI 5
`define ACS_BIT_MODE_RSV 4
`define ACS_BIT_ACTIVE 7
`define ACS_MODE_RESET 8'h10
`define ACS_START_RSV 7'h7F
`define ACS_CH_SIX 4'hA
`define ACS_CH_SEVEN 4'hB

// ****************************************
// Interrupt event bits
// ****************************************
`define ACS_EV_END 0
`define ACS_EV_ABORT 1
`define ACS_EV_W 2

// ****************************************
// Conversion periods in system clock cycles
// ****************************************
`define ACS_PERIOD_SLOW 7'h7C
`define ACS_PERIOD_MID 7'h3E
`define ACS_PERIOD_FAST 7'h1F

`endif

/* design/acs_pkg.sv */
// Types shared by the conversion sequencer modules
package acs_pkg;

   // Sequencer states
   typedef enum logic [1:0] {
      ACS_IDLE = 2'b01,
      ACS_RUN = 2'b10
   } acs_seq_state_type;

   // Successive approximation engine states
   typedef enum logic [2:0] {
      ACS_SAR_IDLE = 3'b001,
      ACS_SAR_SAMPLE = 3'b010,
      ACS_SAR_BITS = 3'b100
   } acs_sar_state_type;

endpackage

/* design/acs_sar.sv */
// Successive approximation engine that walks eight bit decisions over one period
`timescale 1ns/1ns
module acs_sar (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic i_abort,
   input wire logic [6:0] i_period,
   input wire logic i_cmp,
   output logic o_sample,
   output logic [7:0] o_dac_code,
   output logic o_done,
   output logic [7:0] o_result
);

   acs_pkg::acs_sar_state_type st_q;
   logic [6:0] cnt_q;
   logic [2:0] idx_q;
   logic [7:0] code_q;
   logic [6:0] step_w;
   logic [6:0] samp_w;

   // Each bit gets period/8 cycles, sampling takes the rest
   assign step_w = {3'h0, i_period[6:3]};
   assign samp_w = i_period - {i_period[6:3], 3'h0};

   // Sequence of sampling and bit trials
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= acs_pkg::ACS_SAR_IDLE;
         cnt_q <= 7'h00;
         idx_q <= 3'h0;
         code_q <= 8'h00;
      end else if (i_abort) begin
         st_q <= acs_pkg::ACS_SAR_IDLE;
      end else begin
         case (st_q)
            acs_pkg::ACS_SAR_IDLE: begin
               if (i_start) begin
                  st_q <= acs_pkg::ACS_SAR_SAMPLE;
                  cnt_q <= samp_w - 7'h01;
               end
            end
            acs_pkg::ACS_SAR_SAMPLE: begin
               if (cnt_q == 7'h00) begin
                  st_q <= acs_pkg::ACS_SAR_BITS;
                  cnt_q <= step_w - 7'h01;
                  idx_q <= 3'h7;
                  code_q <= 8'h80;
               end else begin
                  cnt_q <= cnt_q - 7'h01;
               end
            end
            acs_pkg::ACS_SAR_BITS: begin
               if (cnt_q == 7'h00) begin
                  code_q[idx_q] <= i_cmp;
                  if (idx_q == 3'h0) begin
                     st_q <= acs_pkg::ACS_SAR_IDLE;
                  end else begin
                     code_q[idx_q - 3'h1] <= 1'b1;
                     idx_q <= idx_q - 3'h1;
                     cnt_q <= step_w - 7'h01;
                  end
               end else begin
                  cnt_q <= cnt_q - 7'h01;
               end
            end
            default: begin
               st_q <= acs_pkg::ACS_SAR_IDLE;
            end
         endcase
      end
   end

   // Outputs toward the analog side and the sequencer
   assign o_sample = (st_q == acs_pkg::ACS_SAR_SAMPLE);
   assign o_dac_code = code_q;
   assign o_done = (st_q == acs_pkg::ACS_SAR_BITS) && (cnt_q == 7'h00) && (idx_q == 3'h0);
   assign o_result = {code_q[7:1], i_cmp};

endmodule

/* design/acs_sequencer.sv */
// Conversion sequencer: registers, start and stop, channel routing, completion and interrupt
//
// Behaviour
// - End of conversion sets the conversion-end request flag as active falls.
// - Software-writable enable bit gates the request flag onto the interrupt.
// - Channel code 1010 routes analog input six to the converter.
// - Writing 1 to the active flag starts a conversion.
// - Result is stored in the same cycle the request flag is set.
// - With the result stored, active clears and the sequencer returns idle.
// - Interrupt is raised while request flag and enable bit are both set.
// - From idle after completion a new start runs a full new conversion.
// - Writing 0 to active during conversion aborts it; do so before mode changes.
// - Top channel bit 0 means none; 101x picks six or seven; others reserved.
// - Speed bits give 124, 62 or 31 cycles; 00 is reserved reset state.
// - With trigger enabled, the selected pin edge starts a conversion.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "acs_params.svh"
module acs_sequencer (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_ext_trigger_pin,
   input wire logic i_trig_edge_rising,
   input wire logic i_cmp,
   output logic o_sample,
   output logic [7:0] o_dac_code,
   output logic o_analog_input_six,
   output logic o_analog_input_seven,
   output logic o_irq
);

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_meta_q;
   logic rst_n_q;

   // Two flops release the reset synchronously
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // ****************************************
   // Declarations
   // ****************************************
   acs_pkg::acs_seq_state_type state_q;
   logic active_q;
   logic [7:0] mode_q;
   logic [7:0] result_q;
   logic [`ACS_EV_W-1:0] status_q;
   logic [`ACS_EV_W-1:0] enable_q;
   logic [7:0] rdata_q;
   logic trig_q;
   logic wr_mode;
   logic wr_start;
   logic wr_clr;
   logic wr_en;
   logic trig_edge;
   logic trig_hit;
   logic start_go;
   logic abort_go;
   logic sar_done;
   logic done_go;
   logic [7:0] sar_result;
   logic [6:0] period_w;
   logic [3:0] chan_w;
   logic [`ACS_EV_W-1:0] ev_set;

   // ****************************************
   // Register decode
   // ****************************************
   assign wr_mode = i_wr && (i_addr == `ACS_ADDR_MODE);
   assign wr_start = i_wr && (i_addr == `ACS_ADDR_START);
   assign wr_clr = i_wr && (i_addr == `ACS_ADDR_IRQ_CLR);
   assign wr_en = i_wr && (i_addr == `ACS_ADDR_IRQ_EN);
   assign chan_w = mode_q[3:0];

   // Mode register, reserved bit stays 1
   always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mode_q <= `ACS_MODE_RESET;
      end else if (wr_mode) begin
         mode_q <= i_wdata | `ACS_MODE_RESET;
      end
   end

   // Interrupt enable register
   always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         enable_q <= '0;
      end else if (wr_en) begin
         enable_q <= i_wdata[`ACS_EV_W-1:0];
      end
   end

   // ****************************************
   // Speed and channel selection
   // ****************************************
   // Reserved speed code runs at the slowest period
   always_comb begin
      case ({mode_q[`ACS_BIT_SPD_HI], mode_q[`ACS_BIT_SPD_LO]})
         2'b01: period_w = `ACS_PERIOD_SLOW;
         2'b10: period_w = `ACS_PERIOD_MID;
         2'b11: period_w = `ACS_PERIOD_FAST;
         default: period_w = `ACS_PERIOD_SLOW;
      endcase
   end

   // Only codes 101x select an input; all others leave both off
   assign o_analog_input_six = (chan_w == `ACS_CH_SIX);
   assign o_analog_input_seven = (chan_w == `ACS_CH_SEVEN);

   // ****************************************
   // Start, trigger and abort
   // ****************************************
   // Previous pin level for edge detection
   always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         trig_q <= 1'b0;
      end else begin
         trig_q <= i_ext_trigger_pin;
      end
   end

   assign trig_edge = i_trig_edge_rising ? (i_ext_trigger_pin && !trig_q) : (!i_ext_trigger_pin && trig_q);
   assign trig_hit = mode_q[`ACS_BIT_EXT_TRIGGER_ENABLE] && trig_edge;
   // A start while running is ignored; a stop only acts while running
   assign start_go = !active_q && ((wr_start && i_wdata[`ACS_BIT_ACTIVE]) || trig_hit);
   assign abort_go = active_q && wr_start && !i_wdata[`ACS_BIT_ACTIVE];
   assign done_go = sar_done && !abort_go;

   // Sequencer state and active flag
   always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= acs_pkg::ACS_IDLE;
         active_q <= 1'b0;
      end else begin
         case (state_q)
            acs_pkg::ACS_IDLE: begin
               if (start_go) begin
                  state_q <= acs_pkg::ACS_RUN;
                  active_q <= 1'b1;
               end
            end
            acs_pkg::ACS_RUN: begin
               if (abort_go || done_go) begin
                  state_q <= acs_pkg::ACS_IDLE;
                  active_q <= 1'b0;
               end
            end
            default: begin
               state_q <= acs_pkg::ACS_IDLE;
               active_q <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // Conversion engine
   // ****************************************
   acs_sar u_sar (
      .i_clk(i_ref_clk),
      .i_rst_n(rst_n_q),
      .i_start(start_go),
      .i_abort(abort_go),
      .i_period(period_w),
      .i_cmp(i_cmp),
      .o_sample(o_sample),
      .o_dac_code(o_dac_code),
      .o_done(sar_done),
      .o_result(sar_result)
   );

   // Result is held until the next completion, not cleared by reset
   always_ff @(posedge i_ref_clk) begin
      if (done_go) begin
         result_q <= sar_result;
      end
   end

   // ****************************************
   // Interrupt status
   // ****************************************
   assign ev_set = {abort_go, done_go};

   // Sticky flags, a new event wins over a clear in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < `ACS_EV_W; gi = gi + 1) begin : g_ev
         always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
               status_q[gi] <= 1'b0;
            end else if (ev_set[gi]) begin
               status_q[gi] <= 1'b1;
            end else if (wr_clr && i_wdata[gi]) begin
               status_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   assign o_irq = |(status_q & enable_q);

   // ****************************************
   // Read port
   // ****************************************
   // Data stand only in the cycle after the read strobe
   always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_q <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `ACS_ADDR_MODE: rdata_q <= mode_q;
            `ACS_ADDR_RESULT: rdata_q <= result_q;
            `ACS_ADDR_START: rdata_q <= {active_q, `ACS_START_RSV};
            `ACS_ADDR_IRQ_STAT: rdata_q <= {6'h00, status_q};
            `ACS_ADDR_IRQ_EN: rdata_q <= {6'h00, enable_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign o_rdata = rdata_q;

   // ****************************************
   // Checks
   // ****************************************
   logic [6:0] run_cnt_q;
   logic [6:0] run_per_q;

   // Helper: cycles since start and period taken at start
   always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         run_cnt_q <= 7'h00;
         run_per_q <= 7'h00;
      end else if (start_go) begin
         run_cnt_q <= 7'h00;
         run_per_q <= period_w;
      end else if (active_q) begin
         run_cnt_q <= run_cnt_q + 7'h01;
      end
   end

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!rst_n_q);

   property p_end_sets_flag;
      done_go |=> status_q[`ACS_EV_END] && $fell(active_q);
   endproperty
   a_end_sets_flag: assert property (p_end_sets_flag) else $error("end flag not set at completion");

   property p_enable_gates;
      status_q[`ACS_EV_END] && !enable_q[`ACS_EV_END] && !status_q[`ACS_EV_ABORT] |-> !o_irq;
   endproperty
   a_enable_gates: assert property (p_enable_gates) else $error("interrupt raised while disabled");

   property p_chan_six;
      chan_w == 4'hA |-> o_analog_input_six && !o_analog_input_seven;
   endproperty
   a_chan_six: assert property (p_chan_six) else $error("channel six not routed");

   property p_start;
      !active_q && wr_start && i_wdata[7] |=> active_q && state_q == acs_pkg::ACS_RUN;
   endproperty
   a_start: assert property (p_start) else $error("write of one did not start");

   property p_result;
      done_go |=> result_q == $past(sar_result) && status_q[`ACS_EV_END];
   endproperty
   a_result: assert property (p_result) else $error("result not stored with flag");

   property p_idle_after;
      done_go |=> !active_q ##0 state_q == acs_pkg::ACS_IDLE;
   endproperty
   a_idle_after: assert property (p_idle_after) else $error("not idle after completion");

   property p_irq;
      done_go && enable_q[`ACS_EV_END] |=> o_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("no interrupt with enable set");

   property p_abort;
      abort_go |=> !active_q && status_q[`ACS_EV_ABORT] && $stable(status_q[`ACS_EV_END]);
   endproperty
   a_abort: assert property (p_abort) else $error("stop write did not abort");

   property p_none;
      !chan_w[3] |-> !o_analog_input_six && !o_analog_input_seven;
   endproperty
   a_none: assert property (p_none) else $error("input routed with no channel");

   property p_period;
      done_go |-> run_cnt_q == run_per_q - 7'h01;
   endproperty
   a_period: assert property (p_period) else $error("conversion period wrong");

   property p_trigger;
      !active_q && trig_hit |=> active_q;
   endproperty
   a_trigger: assert property (p_trigger) else $error("trigger edge did not start");

   property p_sticky;
      status_q[`ACS_EV_END] && !(wr_clr && i_wdata[0]) |=> status_q[`ACS_EV_END];
   endproperty
   a_sticky: assert property (p_sticky) else $error("end flag lost without clear");

   c_done: cover property (start_go ##[1:130] done_go);
   c_abort: cover property (abort_go);
   c_trigger: cover property (trig_hit && !active_q);
   c_again: cover property (done_go ##[1:20] start_go);

endmodule
